// [logic/imirq_core.sv]
// Purpose: Event/status, line sampling, address, timeout and receive FIFO control
// Assumes: Link clock scl_clk comes from the bus engine, runs only during frames
// Notes:   Receive FIFO storage lives in the engine; this block keeps its count
`timescale 1ns/1ps
`default_nettype none

module imirq_core
  import imirq_pkg::*;
#(
  parameter int unsigned N_EV = NUM_EVENTS
) (
  // Clocks and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     scl_clk,
  // Event inputs from engine (system clock, one-cycle pulses)
  input  wire logic [N_EV-1:0]          event_pulse,
  // Interrupt control
  input  wire logic                     master_int_enable,
  input  wire logic                     master_int_clear,
  input  wire logic [N_EV-1:0]          event_mask_bits,
  input  wire logic                     event_mask_enable_set,
  input  wire logic                     event_mask_enable_clr,
  input  wire logic                     event_clear_strobe,
  input  wire logic                     masked_status_select,
  // Interrupt status
  output logic [N_EV-1:0]               raw_status,
  output logic [N_EV-1:0]               masked_status,
  output logic [N_EV-1:0]               event_enable,
  output logic                          summary_status,
  output logic                          irq,
  // Bus pins (raw) and line state
  input  wire logic                     sda_in,
  input  wire logic                     scl_in,
  output logic [1:0]                    line_state,
  // Target address
  input  wire logic [ADDR_WIDTH-1:0]    target_addr,
  input  wire logic                     read_direction_flag,
  input  wire logic                     addr_write,
  input  wire logic                     xfer_start,
  output logic [7:0]                    addr_byte,
  output logic                          addr_byte_valid,
  // Clock-low timeout
  input  wire logic                     timeout_enable,
  input  wire logic [TMO_PROG_WIDTH-1:0] timeout_limit,
  output logic                          timeout_hit,
  // Receive FIFO control
  input  wire logic                     rxf_cfg_write,
  input  wire logic                     rxf_to_slave,
  input  wire logic                     rxf_use_dma,
  input  wire logic [2:0]               rxf_trig_sel,
  input  wire logic                     rxf_flush,
  input  wire logic                     rxf_push,
  input  wire logic                     rxf_pop,
  output logic                          rxf_master_owned,
  output logic                          rxf_slave_owned,
  output logic                          rxf_dma_mode,
  output logic [RXF_CNT_WIDTH-1:0]      rxf_level,
  output logic                          rxf_request,
  output logic                          rxf_dma_req
);

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [N_EV-1:0] ev_all;
  logic            tmo_event;
  logic            rxf_full_ev;
  logic            rxf_req_ev;
  logic [N_EV-1:0] raw_d;
  logic [N_EV-1:0] enable_d;

  always_comb begin
    ev_all                = event_pulse;
    ev_all[EV_TIMEOUT]    = event_pulse[EV_TIMEOUT] | tmo_event;
    ev_all[EV_RX_FULL]    = event_pulse[EV_RX_FULL] | rxf_full_ev;
    ev_all[EV_RX_REQ]     = event_pulse[EV_RX_REQ] | rxf_req_ev;
  end

  always_comb begin
    raw_d = raw_status;
    if (master_int_clear) begin
      raw_d = '0;
    end
    if (event_clear_strobe) begin
      raw_d = raw_d & ~event_mask_bits;
    end
    raw_d = raw_d | ev_all;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      raw_status <= '0;
    end else begin
      raw_status <= raw_d;
    end
  end

  always_comb begin
    enable_d = event_enable;
    if (event_mask_enable_set) begin
      enable_d = enable_d | event_mask_bits;
    end
    if (event_mask_enable_clr) begin
      enable_d = enable_d & ~event_mask_bits;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_enable <= EV_MASK_RST;
    end else begin
      event_enable <= enable_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      masked_status  <= '0;
      summary_status <= 1'b0;
      irq            <= 1'b0;
    end else begin
      masked_status  <= raw_d & enable_d;
      summary_status <= masked_status_select ? (|(raw_d & enable_d)) : (|raw_d);
      // enabled sources, master enable apart from mask
      irq            <= master_int_enable & (|(raw_d & enable_d));
    end
  end

  // ----------------------------------------------------------------
  // Line state sampling
  // ----------------------------------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;

  // pins through three flops, SDA bit 1, SCL bit 0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
      line_state <= 2'h3;
    end else begin
      pin_meta_q               <= {sda_in, scl_in};
      pin_sync_q               <= pin_meta_q;
      line_state[LINE_SDA_BIT] <= pin_sync_q[1];
      line_state[LINE_SCL_BIT] <= pin_sync_q[0];
    end
  end

  // ----------------------------------------------------------------
  // Target address
  // ----------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] addr_q;
  logic                  dir_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= ADDR_RST;
      dir_q  <= 1'b0;
    end else if (addr_write) begin
      addr_q <= target_addr;
      dir_q  <= read_direction_flag;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_byte       <= 8'h00;
      addr_byte_valid <= 1'b0;
    end else begin
      addr_byte_valid <= xfer_start;
      if (xfer_start) begin
        addr_byte <= {addr_q, dir_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock-low timeout (link clock domain)
  // ----------------------------------------------------------------
  // Limit sampled only while counting is held off, never mid-count
  logic [TMO_WIDTH-1:0]      tmo_cnt_q;
  logic                      tmo_tgl_q;
  logic [2:0]                tmo_sync_q;
  logic                      en_meta_q;
  logic                      en_sync_q;
  logic [TMO_PROG_WIDTH-1:0] limit_q;

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      limit_q   <= TMO_LIMIT_RST;
    end else begin
      en_meta_q <= timeout_enable;
      en_sync_q <= en_meta_q;
      if (!en_sync_q) begin
        limit_q <= timeout_limit;
      end
    end
  end

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_cnt_q <= '0;
      tmo_tgl_q <= 1'b0;
    end else if (!en_sync_q || limit_q == TMO_LIMIT_RST) begin
      tmo_cnt_q <= '0;
    end else if (tmo_cnt_q == {limit_q, {TMO_LOW_WIDTH{1'b1}}}) begin
      tmo_cnt_q <= '0;
      tmo_tgl_q <= ~tmo_tgl_q;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end
  end

  // Toggle crosses as an event
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmo_sync_q  <= 3'h0;
      timeout_hit <= 1'b0;
    end else begin
      tmo_sync_q  <= {tmo_sync_q[1:0], tmo_tgl_q};
      timeout_hit <= tmo_event;
    end
  end
  assign tmo_event = tmo_sync_q[2] ^ tmo_sync_q[1];

  // ----------------------------------------------------------------
  // Receive FIFO control
  // ----------------------------------------------------------------
  logic [2:0]              trig_q;
  logic [RXF_CNT_WIDTH-1:0] level_d;
  logic                    req_d;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxf_master_owned <= 1'b1;
      rxf_slave_owned  <= 1'b0;
      rxf_dma_mode     <= 1'b0;
      trig_q           <= RXF_TRIG_RST;
    end else if (rxf_cfg_write) begin
      rxf_master_owned <= ~rxf_to_slave;
      rxf_slave_owned  <= rxf_to_slave;
      rxf_dma_mode     <= rxf_use_dma;
      trig_q           <= rxf_trig_sel;
    end
  end

  always_comb begin
    level_d = rxf_level;
    if (rxf_flush) begin
      level_d = '0;
    end else if (rxf_push && !rxf_pop && rxf_level != RXF_CNT_WIDTH'(RXF_DEPTH)) begin
      level_d = rxf_level + 1'b1;
    end else if (rxf_pop && !rxf_push && rxf_level != '0) begin
      level_d = rxf_level - 1'b1;
    end
  end

  // trigger code 0..7 means 1..8 entries
  assign req_d       = level_d >= ({1'b0, trig_q} + 4'h1);
  assign rxf_full_ev = rxf_master_owned && level_d == RXF_CNT_WIDTH'(RXF_DEPTH)
                       && rxf_level != RXF_CNT_WIDTH'(RXF_DEPTH);
  assign rxf_req_ev  = rxf_master_owned && req_d && !rxf_request;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxf_level   <= '0;
      rxf_request <= 1'b0;
      rxf_dma_req <= 1'b0;
    end else begin
      rxf_level   <= level_d;
      rxf_request <= req_d;
      rxf_dma_req <= req_d & rxf_dma_mode;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sticky;
    @(posedge clk) disable iff (!resetn)
    (raw_status[EV_DATA] && !master_int_clear && !event_clear_strobe) |=> raw_status[EV_DATA];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Raw bit dropped without clear");

  property p_master_clear;
    @(posedge clk) disable iff (!resetn)
    (master_int_clear && ev_all == '0) |=> raw_status == '0 && !irq;
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("Master clear left pending");

  property p_sel_clear;
    @(posedge clk) disable iff (!resetn)
    (event_clear_strobe && !master_int_clear) |=>
      raw_status == (($past(raw_status) & ~$past(event_mask_bits)) | $past(ev_all));
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("Selective clear wrong");

  property p_irq_enabled;
    @(posedge clk) disable iff (!resetn)
    irq |-> $past(master_int_enable) && (|masked_status);
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("Irq without enabled source");

  property p_master_en;
    @(posedge clk) disable iff (!resetn)
    !master_int_enable |=> !irq;
  endproperty
  a_master_en: assert property (p_master_en) else $error("Irq with master disabled");

  property p_masked;
    @(posedge clk) disable iff (!resetn)
    masked_status == (raw_status & event_enable);
  endproperty
  a_masked: assert property (p_masked) else $error("Masked status mismatch");

  property p_line;
    @(posedge clk) disable iff (!resetn)
    ##3 line_state == {$past(sda_in, 3), $past(scl_in, 3)};
  endproperty
  a_line: assert property (p_line) else $error("Line state not three cycles behind pins");

  property p_addr;
    @(posedge clk) disable iff (!resetn)
    xfer_start |=> addr_byte_valid && addr_byte == {addr_q, dir_q};
  endproperty
  a_addr: assert property (p_addr) else $error("Address byte wrong");

  property p_owner;
    @(posedge clk) disable iff (!resetn)
    rxf_master_owned != rxf_slave_owned;
  endproperty
  a_owner: assert property (p_owner) else $error("FIFO owner not unique");

  sequence s_flush;
    rxf_flush;
  endsequence
  property p_flush;
    @(posedge clk) disable iff (!resetn)
    s_flush |=> rxf_level == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("Flush left entries");

  property p_tmo;
    @(posedge scl_clk) disable iff (!resetn)
    tmo_cnt_q <= {limit_q, {TMO_LOW_WIDTH{1'b1}}} || limit_q == TMO_LIMIT_RST;
  endproperty
  a_tmo: assert property (p_tmo) else $error("Timeout counter over limit");

endmodule
`default_nettype wire

// [logic/imirq_pkg.sv]
// Purpose: Constants shared by the two-wire master event block
// Assumes: 100 MHz system clock
// Notes:   Event bit order fixed here
`default_nettype none
package imirq_pkg;
  localparam int unsigned NUM_EVENTS      = 12;
  // Event bit positions
  localparam int unsigned EV_RX_FULL      = 0;
  localparam int unsigned EV_TX_EMPTY     = 1;
  localparam int unsigned EV_RX_REQ       = 2;
  localparam int unsigned EV_TX_REQ       = 3;
  localparam int unsigned EV_ARB_LOST     = 4;
  localparam int unsigned EV_STOP         = 5;
  localparam int unsigned EV_START        = 6;
  localparam int unsigned EV_NACK         = 7;
  localparam int unsigned EV_TX_DMA_DONE  = 8;
  localparam int unsigned EV_RX_DMA_DONE  = 9;
  localparam int unsigned EV_TIMEOUT      = 10;
  localparam int unsigned EV_DATA         = 11;
  // Line state field positions
  localparam int unsigned LINE_SCL_BIT    = 0;
  localparam int unsigned LINE_SDA_BIT    = 1;
  // Timeout counter layout
  localparam int unsigned TMO_WIDTH       = 12;
  localparam int unsigned TMO_PROG_WIDTH  = 8;
  localparam int unsigned TMO_LOW_WIDTH   = TMO_WIDTH - TMO_PROG_WIDTH;
  // Receive FIFO and target address width
  localparam int unsigned RXF_DEPTH       = 8;
  localparam int unsigned RXF_CNT_WIDTH   = 4;
  localparam int unsigned ADDR_WIDTH      = 7;
  // Reset values
  localparam logic [11:0] EV_MASK_RST     = 12'h000;
  localparam logic [7:0]  TMO_LIMIT_RST   = 8'h00;
  localparam logic [2:0]  RXF_TRIG_RST    = 3'h0;
  localparam logic [6:0]  ADDR_RST        = 7'h00;
endpackage
`default_nettype wire

// [testbench/i2c_master_irq_timeout_rxfifo_tb.sv]
// Purpose: Self-checking bench of the event, line, address, timeout and FIFO logic
// Assumes: Design assertions run alongside
// Notes:   FIFO scenarios come after the event table, internal FIFO events stay quiet there
`timescale 1ns/1ps
`default_nettype none
module i2c_master_irq_timeout_rxfifo_tb
  import imirq_pkg::*;
;
  typedef struct {int ev; logic [11:0] en; logic men; logic sel; logic irq; logic sum;} imirq_row_t;
  logic clk = 0, resetn = 0, frame = 0, sda_low = 0, scl_low = 0;
  logic scl_clk, sda_in, scl_in, summary_status, irq, addr_byte_valid, timeout_hit;
  logic [11:0] event_pulse = 0, event_mask_bits = 0, raw_status, masked_status, event_enable;
  logic master_int_enable = 0, master_int_clear = 0, event_mask_enable_set = 0;
  logic event_mask_enable_clr = 0, event_clear_strobe = 0, masked_status_select = 0;
  logic [1:0] line_state;
  logic [6:0] target_addr = 0;
  logic read_direction_flag = 0, addr_write = 0, xfer_start = 0, timeout_enable = 0;
  logic [7:0] addr_byte, timeout_limit = 0;
  logic rxf_cfg_write = 0, rxf_to_slave = 0, rxf_use_dma = 0, rxf_flush = 0, rxf_push = 0, rxf_pop = 0;
  logic [2:0] rxf_trig_sel = 0;
  logic rxf_master_owned, rxf_slave_owned, rxf_dma_mode, rxf_request, rxf_dma_req;
  logic [3:0] rxf_level;
  int err_count = 0, checks = 0, cycles = 0, scl_cnt = 0;
  int hit_cnt = 0, scl_base = 0;
  logic hit_seen = 0;
  imirq_row_t rows [12] = '{
    '{0, 12'h001, 1, 1, 1, 1}, '{1, 12'h000, 1, 1, 0, 0}, '{2, 12'h004, 0, 0, 0, 1},
    '{3, 12'hff7, 1, 1, 0, 0}, '{4, 12'h010, 1, 0, 1, 1}, '{5, 12'hfff, 1, 1, 1, 1},
    '{6, 12'h000, 1, 0, 0, 1}, '{7, 12'h080, 1, 1, 1, 1}, '{8, 12'h100, 0, 0, 0, 1},
    '{9, 12'he00, 1, 1, 1, 1}, '{10, 12'h400, 1, 1, 1, 1}, '{11, 12'h7ff, 1, 1, 0, 0}};

  always #5 clk = ~clk;

  imirq_core imirq_core_i (.clk, .resetn, .scl_clk, .event_pulse, .master_int_enable,
    .master_int_clear, .event_mask_bits, .event_mask_enable_set, .event_mask_enable_clr,
    .event_clear_strobe, .masked_status_select, .raw_status, .masked_status, .event_enable,
    .summary_status, .irq, .sda_in, .scl_in, .line_state, .target_addr, .read_direction_flag,
    .addr_write, .xfer_start, .addr_byte, .addr_byte_valid, .timeout_enable, .timeout_limit,
    .timeout_hit, .rxf_cfg_write, .rxf_to_slave, .rxf_use_dma, .rxf_trig_sel, .rxf_flush,
    .rxf_push, .rxf_pop, .rxf_master_owned, .rxf_slave_owned, .rxf_dma_mode, .rxf_level,
    .rxf_request, .rxf_dma_req);

  imirq_target_model imirq_target_model_i (.frame, .sda_low, .scl_low, .scl_clk, .sda_in, .scl_in);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (timeout_hit === 1'b1) hit_seen <= 1'b1;
    if (timeout_hit === 1'b1 && hit_seen !== 1'b1) hit_cnt <= scl_cnt;
    if (cycles > 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  always @(posedge scl_clk) scl_cnt <= scl_cnt + 1;

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count = err_count + 1;
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic push_n(int n);
    rxf_push = 1'b1;
    tick(n);
    rxf_push = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(16);
    resetn = 1'b1;
    tick(2);
    chk("reset line_state", 12'h3, line_state);
    chk("reset owner", 12'h1, rxf_master_owned);
    chk("reset raw", 12'h0, raw_status);
    // Ordinary cases: one row per event source
    foreach (rows[i]) begin
      pulse(master_int_clear);
      event_mask_bits = 12'hfff;
      pulse(event_mask_enable_clr);
      event_mask_bits = rows[i].en;
      pulse(event_mask_enable_set);
      master_int_enable = rows[i].men;
      masked_status_select = rows[i].sel;
      event_pulse = 12'h001 << rows[i].ev;
      tick();
      event_pulse = 12'h000;
      tick(3);
      chk("raw", 12'h001 << rows[i].ev, raw_status);
      chk("enable", rows[i].en, event_enable);
      chk("masked", rows[i].en & (12'h001 << rows[i].ev), masked_status);
      chk("irq", rows[i].irq, irq);
      chk("summary", rows[i].sum, summary_status);
    end
    // Selective clear keeps the other source
    pulse(master_int_clear);
    event_mask_bits = 12'hfff;
    pulse(event_mask_enable_clr);
    event_pulse = 12'h011;
    tick();
    event_pulse = 12'h000;
    event_mask_bits = 12'h001;
    pulse(event_clear_strobe);
    tick();
    chk("mask clear", 12'h010, raw_status);
    chk("irq disabled", 12'h0, irq);
    master_int_enable = 1'b1;
    event_mask_bits = 12'h010;
    pulse(event_mask_enable_set);
    tick();
    chk("irq pending", 12'h1, irq);
    pulse(master_int_clear);
    tick();
    chk("master clear raw", 12'h0, raw_status);
    chk("master clear irq", 12'h0, irq);
    // Line state follows pins
    for (int k = 0; k < 4; k++) begin
      sda_low = k[1];
      scl_low = k[0];
      tick(4);
      chk("line_state", {10'h0, ~k[1], ~k[0]}, line_state);
    end
    sda_low = 1'b0;
    scl_low = 1'b0;
    // Address held from load, not live inputs
    target_addr = 7'h5a;
    read_direction_flag = 1'b1;
    pulse(addr_write);
    target_addr = 7'h21;
    read_direction_flag = 1'b0;
    xfer_start = 1'b1;
    tick();
    xfer_start = 1'b0;
    for (int w = 0; w < 4 && addr_byte_valid !== 1'b1; w++) tick();
    chk("addr valid", 12'h1, addr_byte_valid);
    chk("addr byte", 12'h0b5, addr_byte);
    // Timeout off, then on with limit one
    timeout_limit = 8'h01;
    frame = 1'b1;
    repeat (40) @(posedge scl_clk);
    tick();
    chk("timeout disabled", 12'h0, hit_seen);
    frame = 1'b0;
    tick(20);
    timeout_enable = 1'b1;
    tick();
    scl_base = scl_cnt;
    frame = 1'b1;
    for (int w = 0; w < 60 && hit_seen !== 1'b1; w++) @(posedge scl_clk);
    tick(4);
    frame = 1'b0;
    chk("timeout hit", 12'h1, hit_seen);
    chk("timeout span", 12'h1, hit_cnt - scl_base >= 31 && hit_cnt - scl_base <= 34);
    chk("timeout raw", 12'h1, raw_status[EV_TIMEOUT]);
    timeout_enable = 1'b0;
    // FIFO trigger at three, fill past full, flush
    rxf_trig_sel = 3'h2;
    pulse(rxf_cfg_write);
    push_n(2);
    tick();
    chk("rx req below", 12'h0, rxf_request);
    push_n(1);
    tick();
    chk("rx req at trig", 12'h1, rxf_request);
    push_n(6);
    tick();
    chk("rx level full", 12'h8, rxf_level);
    chk("rx full event", 12'h1, raw_status[EV_RX_FULL]);
    pulse(rxf_pop);
    tick();
    chk("rx level pop", 12'h7, rxf_level);
    pulse(rxf_flush);
    tick();
    chk("rx flush", 12'h0, rxf_level);
    chk("rx req flush", 12'h0, rxf_request);
    // DMA service, then slave ownership
    rxf_use_dma = 1'b1;
    rxf_trig_sel = 3'h0;
    pulse(rxf_cfg_write);
    push_n(1);
    tick();
    chk("dma mode", 12'h1, rxf_dma_mode);
    chk("dma req", 12'h1, rxf_dma_req);
    rxf_to_slave = 1'b1;
    rxf_use_dma = 1'b0;
    pulse(rxf_cfg_write);
    tick();
    chk("slave owned", 12'h1, rxf_slave_owned);
    chk("master owned", 12'h0, rxf_master_owned);
    chk("dma off", 12'h0, rxf_dma_mode);
    // Mid-run reset restores defaults
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(2);
    chk("reset2 raw", 12'h0, raw_status);
    chk("reset2 owner", 12'h1, rxf_master_owned);
    stop_test();
  end
endmodule
`default_nettype wire

// [testbench/imirq_target_model.sv]
// Purpose: Two-wire bus targets as seen from the event block
// Assumes: Link clock of 125 ns period, only inside frames
// Notes:   Lines are open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
module imirq_target_model (
  // Frame control from bench
  input  wire logic frame,
  input  wire logic sda_low,
  input  wire logic scl_low,
  // Bus side
  output logic      scl_clk,
  output logic      sda_in,
  output logic      scl_in
);
  // ----------------------------------------
  // Link clock
  // ----------------------------------------
  // Stands still between frames, odd phase to clk
  always begin
    scl_clk = 1'b0;
    #7;
    if (frame) begin
      #55.5 scl_clk = 1'b1;
      #62.5;
    end
  end
  // ----------------------------------------
  // Open-drain lines
  // ----------------------------------------
  // Released line floats high by pull-up
  assign sda_in = sda_low ? 1'b0 : 1'b1;
  assign scl_in = scl_low ? 1'b0 : 1'b1;
endmodule
`default_nettype wire
